// ---- logic/osc_source_ctrl.sv ----
// oscillator source control: trim, spread spectrum, source select, external osc
// Functional notes
// - triangle modulation period of 384 oscillator cycles
// - modulation only lowers, max 1.6%, 0.26% steps
// - trim resets to factory 24.5 MHz value
// - low power oscillator selected after reset
// - low power oscillator enabled only while selected
// - external clock to sysclk mux and peripherals
// - divide-by-2 stage gives 50% duty
// - valid flag rises after oscillation stabilises
// - valid reads zero in CMOS clock mode
// - calibration bit 7 enable, bits 6:0 trim
// - source select decode, other codes reserved
`timescale 1ns/1ps
`default_nettype none
`include "osc_ctrl_params.svh"
module osc_source_ctrl #(
   parameter int unsigned SSM_PERIOD = `SSM_PERIOD_CYCLES
) (
   input  wire logic                   clk_i,
   input  wire logic                   rstn_i,
   input  wire logic                   prec_osc_clk_i,
   input  wire logic                   cal_we_i,
   input  wire logic [7:0]             cal_wdata_i,
   input  wire logic                   sel_we_i,
   input  wire logic [2:0]             sel_wdata_i,
   input  wire logic [2:0]             ext_mode_i,
   input  wire logic [2:0]             ext_freq_control_i,
   input  wire logic                   ext_osc_clk_i,
   input  wire logic                   ext_osc_stable_i,
   output logic [7:0]                  precision_osc_trim_o,
   output logic [6:0]                  trim_effective_o,
   output logic [2:0]                  ssm_step_o,
   output osc_ctrl_pkg::clk_src_t      sysclk_source_select_o,
   output logic                        lp_osc_enable_o,
   output logic                        ext_osc_enable_o,
   output logic [2:0]                  ext_freq_bias_o,
   output logic                        ext_clk_periph_o,
   output logic                        ext_osc_valid_flag_o
);
   import osc_ctrl_pkg::*;

   logic [7:0]  cal_q;
   logic [8:0]  ssm_cnt_q;
   logic [2:0]  step_q;
   logic        prev_pclk_q;
   logic        pclk_rise;
   logic        ext_on;
   logic        div2;
   logic        vsync;
   logic        ext_clk;
   clk_src_t    sel_q;

   function automatic clk_src_t decode_src(input logic [2:0] code);
      unique case (code)
         `SEL_PRECISION: decode_src = src_precision;
         `SEL_EXTERNAL:  decode_src = src_external;
         `SEL_LP_DIV8:   decode_src = src_lp_div8;
         `SEL_RTC:       decode_src = src_rtc;
         `SEL_LP:        decode_src = src_lp;
         default:        decode_src = src_reserved;
      endcase
   endfunction : decode_src

   // both cmos modes bypass the valid detector
   function automatic logic is_cmos(input logic [2:0] mode);
      is_cmos = (mode == `XMODE_CMOS) || (mode == `XMODE_CMOS_DIV2);
   endfunction : is_cmos

   function automatic logic is_div2(input logic [2:0] mode);
      is_div2 = (mode == `XMODE_XTAL_DIV2) || (mode == `XMODE_CMOS_DIV2);
   endfunction : is_div2

   function automatic logic uses_lp(input clk_src_t src);
      uses_lp = (src == src_lp) || (src == src_lp_div8);
   endfunction : uses_lp

   // slot index; assumes the period is a whole number of slots
   function automatic logic [3:0] slot_of(input logic [8:0] cnt);
      slot_of = 4'(cnt / 9'(`SSM_STEP_CYCLES));
   endfunction : slot_of

   // slots 0..6 climb to the deepest step, 7..11 fall back towards nominal
   function automatic logic [2:0] tri_step(input logic [3:0] slot);
      if (slot <= 4'(`SSM_STEPS))
         tri_step = 3'(slot);
      else
         tri_step = 3'(4'(2 * `SSM_STEPS) - slot);
   endfunction : tri_step

   // calibration register; trim is a factory value on reset
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cal_q <= `CAL_RESET_VALUE;
      end else if (cal_we_i) begin
         cal_q <= cal_wdata_i;
      end
   end

   // reserved codes are ignored so the mux never sees an illegal source
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sel_q <= src_lp;
      end else if (sel_we_i && decode_src(sel_wdata_i) != src_reserved) begin
         sel_q <= decode_src(sel_wdata_i);
      end
   end

   assign pclk_rise = prec_osc_clk_i & ~prev_pclk_q;

   // previous level of the precision clock for edge detection
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_pclk_q <= 1'b0;
      end else begin
         prev_pclk_q <= prec_osc_clk_i;
      end
   end

   // count oscillator edges; one triangle every 384 edges
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ssm_cnt_q <= 9'h000;
      end else begin
         if (!cal_q[`CAL_SSE_BIT])
            ssm_cnt_q <= 9'h000;
         else if (pclk_rise)
            ssm_cnt_q <= (ssm_cnt_q == 9'(SSM_PERIOD - 1)) ? 9'h000
                         : ssm_cnt_q + 9'h001;
      end
   end

   // slot of 32 cycles, 12 slots; step 0 is nominal, 6 is lowest
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         step_q <= 3'h0;
      end else if (!cal_q[`CAL_SSE_BIT]) begin
         step_q <= 3'h0;
      end else begin
         step_q <= tri_step(slot_of(ssm_cnt_q));
      end
   end

   // lower trim lowers frequency; one code is about one 0.26% step
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         trim_effective_o <= `TRIM_RESET_VALUE;
         ssm_step_o       <= 3'h0;
      end else begin
         ssm_step_o       <= step_q;
         trim_effective_o <= (cal_q[6:0] > 7'(step_q)) ?
                             cal_q[6:0] - 7'(step_q) : 7'h00;
      end
   end

   // mode decode shared by the divider and the enable output
   assign ext_on = ext_mode_i != `XMODE_OFF;
   assign div2   = is_div2(ext_mode_i);

   ext_osc_divider u_div (
      .clk_i        (clk_i),
      .rstn_i       (rstn_i),
      .ext_clk_i    (ext_osc_clk_i),
      .div2_en_i    (div2),
      .osc_on_i     (ext_on),
      .valid_raw_i  (ext_osc_stable_i),
      .ext_clk_o    (ext_clk),
      .valid_sync_o (vsync)
   );

   // calibration readback straight from the register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         precision_osc_trim_o <= `CAL_RESET_VALUE;
      end else begin
         precision_osc_trim_o <= cal_q;
      end
   end

   // lp osc follows the selected source, so it never runs unused
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sysclk_source_select_o <= src_lp;
         lp_osc_enable_o        <= 1'b1;
      end else begin
         sysclk_source_select_o <= sel_q;
         lp_osc_enable_o        <= uses_lp(sel_q);
      end
   end

   // peripheral clock taps the external path ahead of the source mux
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ext_osc_enable_o <= 1'b0;
         ext_freq_bias_o  <= 3'h0;
         ext_clk_periph_o <= 1'b0;
      end else begin
         ext_osc_enable_o <= ext_on;
         ext_freq_bias_o  <= ext_freq_control_i;
         ext_clk_periph_o <= ext_clk;
      end
   end

   // cmos mode has no detector, so the flag is held low
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ext_osc_valid_flag_o <= 1'b0;
      end else begin
         ext_osc_valid_flag_o <= vsync && !is_cmos(ext_mode_i);
      end
   end
endmodule : osc_source_ctrl
`default_nettype wire

// ---- logic/osc_ctrl_params.svh ----
// constants for the oscillator source control block
`ifndef OSC_CTRL_PARAMS_SVH
`define OSC_CTRL_PARAMS_SVH
`define SSM_PERIOD_CYCLES    384
`define SSM_STEP_CYCLES      32
`define SSM_STEPS            6
`define TRIM_RESET_VALUE     7'h40
`define CAL_SSE_BIT          7
`define CAL_RESET_VALUE      8'h40
`define SEL_PRECISION        3'h0
`define SEL_EXTERNAL         3'h1
`define SEL_LP_DIV8          3'h2
`define SEL_RTC              3'h3
`define SEL_LP               3'h4
`define SEL_RESET_VALUE      3'h4
`define XMODE_OFF            3'h0
`define XMODE_CMOS           3'h2
`define XMODE_CMOS_DIV2      3'h3
`define XMODE_RC             3'h4
`define XMODE_CAP            3'h5
`define XMODE_XTAL           3'h6
`define XMODE_XTAL_DIV2      3'h7
`endif

// ---- logic/osc_ctrl_pkg.sv ----
// types for the oscillator source control block
package osc_ctrl_pkg;
   typedef enum logic [2:0] {
      src_precision,
      src_external,
      src_lp_div8,
      src_rtc,
      src_lp,
      src_reserved
   } clk_src_t;
endpackage : osc_ctrl_pkg

// ---- logic/ext_osc_divider.sv ----
// external oscillator divide-by-2 toggle and valid synchroniser
`timescale 1ns/1ps
`default_nettype none
module ext_osc_divider (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic ext_clk_i,
   input  wire logic div2_en_i,
   input  wire logic osc_on_i,
   input  wire logic valid_raw_i,
   output logic      ext_clk_o,
   output logic      valid_sync_o
);
   logic half_q;
   logic prev_q;
   logic v1_q;
   logic v2_q;

   // toggling on each rising edge gives exactly 50% duty
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_q <= 1'b0;
         half_q <= 1'b0;
      end else begin
         prev_q <= ext_clk_i;
         if (!osc_on_i)
            half_q <= 1'b0;
         else if (ext_clk_i && !prev_q)
            half_q <= ~half_q;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ext_clk_o <= 1'b0;
      end else begin
         ext_clk_o <= osc_on_i & (div2_en_i ? half_q : ext_clk_i);
      end
   end

   // two flops; first one feeds only the second
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         v1_q <= 1'b0;
         v2_q <= 1'b0;
      end else begin
         v1_q <= valid_raw_i;
         v2_q <= v1_q;
      end
   end

   assign valid_sync_o = v2_q & osc_on_i;
endmodule : ext_osc_divider
`default_nettype wire

// ---- bench/osc_source_ctrl_assertions.sv ----
// assertion checker for the oscillator source control block
`timescale 1ns/1ps
`default_nettype none
`include "osc_ctrl_params.svh"
module osc_source_ctrl_checker
   import osc_ctrl_pkg::*;
(
   input wire logic                   clk_i,
   input wire logic                   rstn_i,
   input wire logic                   cal_we_i,
   input wire logic [7:0]             cal_wdata_i,
   input wire logic                   sel_we_i,
   input wire logic [2:0]             sel_wdata_i,
   input wire logic [2:0]             ext_mode_i,
   input wire logic [2:0]             ext_freq_control_i,
   input wire logic                   ext_osc_stable_i,
   input wire logic [7:0]             precision_osc_trim_o,
   input wire logic [6:0]             trim_effective_o,
   input wire logic [2:0]             ssm_step_o,
   input wire osc_ctrl_pkg::clk_src_t sysclk_source_select_o,
   input wire logic                   lp_osc_enable_o,
   input wire logic                   ext_osc_enable_o,
   input wire logic [2:0]             ext_freq_bias_o,
   input wire logic                   ext_osc_valid_flag_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   a_cal_write_lands: assert property (cal_we_i |-> ##2 precision_osc_trim_o == $past(cal_wdata_i, 2))
      else $error("calibration readback wrong");
   a_sel_write_lands: assert property (sel_we_i && sel_wdata_i < 3'h5 ##1 !sel_we_i
      |=> sysclk_source_select_o == $past(sel_wdata_i, 2)) else $error("source select wrong");
   a_sel_reserved_ignored: assert property (sel_we_i && sel_wdata_i > 3'h4 |-> ##2 $stable(sysclk_source_select_o))
      else $error("reserved select taken");
   a_lp_follows_sel: assert property (lp_osc_enable_o == (sysclk_source_select_o inside {src_lp, src_lp_div8}))
      else $error("low power enable wrong");
   a_ext_enable_mode: assert property (ext_osc_enable_o == ($past(ext_mode_i) != `XMODE_OFF))
      else $error("external enable wrong");
   a_bias_passes: assert property (ext_freq_bias_o == $past(ext_freq_control_i))
      else $error("frequency bias wrong");
   a_valid_cmos_zero: assert property ($past(ext_mode_i) inside {3'h0, 3'h2, 3'h3} |-> !ext_osc_valid_flag_o)
      else $error("valid set in cmos or off mode");
   a_valid_rises: assert property ((ext_osc_stable_i && ext_mode_i == `XMODE_XTAL)[*4] |-> ext_osc_valid_flag_o)
      else $error("valid did not rise");
   a_step_bounded: assert property (ssm_step_o <= 3'h6 && trim_effective_o <= precision_osc_trim_o[6:0])
      else $error("modulation raised frequency");
   c_cal: cover property (cal_we_i && cal_wdata_i[7]);
   c_valid: cover property ($rose(ext_osc_valid_flag_o));
   c_step: cover property (ssm_step_o == 3'h6);
endmodule : osc_source_ctrl_checker
bind osc_source_ctrl osc_source_ctrl_checker chk_i (.clk_i(clk_i), .rstn_i(rstn_i),
   .cal_we_i(cal_we_i), .cal_wdata_i(cal_wdata_i), .sel_we_i(sel_we_i), .sel_wdata_i(sel_wdata_i),
   .ext_mode_i(ext_mode_i), .ext_freq_control_i(ext_freq_control_i),
   .ext_osc_stable_i(ext_osc_stable_i), .precision_osc_trim_o(precision_osc_trim_o),
   .trim_effective_o(trim_effective_o), .ssm_step_o(ssm_step_o),
   .sysclk_source_select_o(sysclk_source_select_o), .lp_osc_enable_o(lp_osc_enable_o),
   .ext_osc_enable_o(ext_osc_enable_o), .ext_freq_bias_o(ext_freq_bias_o),
   .ext_osc_valid_flag_o(ext_osc_valid_flag_o));
`default_nettype wire

// ---- bench/osc_source_ctrl_tb.sv ----
// self-checking bench for the oscillator source control block
`timescale 1ns/1ps
`default_nettype none
module osc_source_ctrl_tb;
   import osc_ctrl_pkg::*;
   logic       clk_i = 0, rstn_i = 0, prec_osc_clk_i = 0, cal_we_i = 0, sel_we_i = 0;
   logic       ext_osc_clk_i = 0, ext_osc_stable_i = 0, pv;
   logic [7:0] cal_wdata_i = 0, precision_osc_trim_o, d;
   logic [2:0] sel_wdata_i = 0, ext_mode_i = 0, ext_freq_control_i = 0, ssm_step_o;
   logic [2:0] ext_freq_bias_o, mx, cur, f;
   logic [6:0] trim_effective_o, mn;
   clk_src_t   sysclk_source_select_o;
   logic       lp_osc_enable_o, ext_osc_enable_o, ext_clk_periph_o, ext_osc_valid_flag_o;
   int         errors = 0, n_checks = 0, n;
   logic [2:0] modes [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
   logic [2:0] starts [3] = '{3'h6, 3'h4, 3'h5};
   always #2.5 clk_i = ~clk_i;
   // both oscillators run at half the system clock, the fastest rate the edge detectors can sample
   always @(posedge clk_i) begin
      prec_osc_clk_i <= ~prec_osc_clk_i;
      ext_osc_clk_i  <= ~ext_osc_clk_i;
   end
   osc_source_ctrl uut (.clk_i(clk_i), .rstn_i(rstn_i), .prec_osc_clk_i(prec_osc_clk_i),
      .cal_we_i(cal_we_i), .cal_wdata_i(cal_wdata_i), .sel_we_i(sel_we_i),
      .sel_wdata_i(sel_wdata_i), .ext_mode_i(ext_mode_i), .ext_freq_control_i(ext_freq_control_i),
      .ext_osc_clk_i(ext_osc_clk_i), .ext_osc_stable_i(ext_osc_stable_i),
      .precision_osc_trim_o(precision_osc_trim_o), .trim_effective_o(trim_effective_o),
      .ssm_step_o(ssm_step_o), .sysclk_source_select_o(sysclk_source_select_o),
      .lp_osc_enable_o(lp_osc_enable_o), .ext_osc_enable_o(ext_osc_enable_o),
      .ext_freq_bias_o(ext_freq_bias_o), .ext_clk_periph_o(ext_clk_periph_o),
      .ext_osc_valid_flag_o(ext_osc_valid_flag_o));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   // reserved codes leave the previous source in place
   function automatic logic [2:0] exp_src(input logic [2:0] c, input logic [2:0] p);
      return (c < 3'h5) ? c : p;
   endfunction : exp_src
   initial begin
      #50000;
      errors++;
      finish_test();
   end
   initial begin
      void'($urandom(35766));
      repeat (5) @(posedge clk_i);
      rstn_i <= 1;
      @(negedge clk_i);
      chk(precision_osc_trim_o, 8'h40);
      chk(8'(sysclk_source_select_o), 8'h4);
      chk(8'(lp_osc_enable_o), 8'h1);
      cur = 3'h4;
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_i);
         sel_we_i <= 1;
         sel_wdata_i <= 3'(c);
         @(posedge clk_i);
         sel_we_i <= 0;
         repeat (2) @(posedge clk_i);
         cur = exp_src(3'(c), cur);
         @(negedge clk_i);
         chk(8'(sysclk_source_select_o), 8'(cur));
         chk(8'(lp_osc_enable_o), 8'(cur == 3'h4 || cur == 3'h2));
      end
      for (int s = 1; s >= 0; s--) begin
         d = {1'(s), 7'($urandom_range(127, 10))};
         @(posedge clk_i);
         cal_we_i <= 1;
         cal_wdata_i <= d;
         @(posedge clk_i);
         cal_we_i <= 0;
         repeat (4) @(negedge clk_i);
         chk(precision_osc_trim_o, d);
         mx = 0;
         mn = 7'h7f;
         // 800 cycles hold 400 oscillator edges, more than one full triangle
         repeat (800) begin
            @(negedge clk_i);
            if (ssm_step_o > mx) mx = ssm_step_o;
            if (trim_effective_o < mn) mn = trim_effective_o;
         end
         chk(8'(mx), s ? 8'h6 : 8'h0);
         chk(8'(mn), 8'(d[6:0] - (s ? 7'h6 : 7'h0)));
      end
      foreach (modes[i]) begin
         f = 3'($urandom);
         @(posedge clk_i);
         ext_mode_i <= modes[i];
         ext_freq_control_i <= f;
         ext_osc_stable_i <= 1;
         repeat (6) @(negedge clk_i);
         chk(8'(ext_osc_enable_o), 8'(modes[i] != 3'h0));
         chk(8'(ext_osc_valid_flag_o), 8'(modes[i] >= 3'h4));
         chk(8'(ext_freq_bias_o), 8'(f));
         n = 0;
         pv = ext_clk_periph_o;
         repeat (16) begin
            @(negedge clk_i);
            if (ext_clk_periph_o !== pv) n++;
            pv = ext_clk_periph_o;
         end
         chk(8'(n), modes[i] == 3'h0 ? 8'h0 :
             ((modes[i] == 3'h3 || modes[i] == 3'h7) ? 8'h8 : 8'h10));
      end
      @(posedge clk_i);
      ext_mode_i <= 3'h0;
      repeat (2) @(negedge clk_i);
      chk(8'(ext_osc_valid_flag_o), 8'h0);
      // start-up order: enable, poll the flag, only then move the system clock
      foreach (starts[i]) begin
         @(posedge clk_i);
         ext_mode_i <= 3'h0;
         ext_osc_stable_i <= 0;
         repeat (4) @(negedge clk_i);
         chk(8'(ext_osc_valid_flag_o), 8'h0);
         @(posedge clk_i);
         ext_mode_i <= starts[i];
         ext_freq_control_i <= 3'($urandom);
         repeat (4 + $urandom_range(8)) @(negedge clk_i);
         chk(8'(ext_osc_valid_flag_o), 8'h0);
         @(posedge clk_i);
         ext_osc_stable_i <= 1;
         n = 0;
         // three edges to the flag, seen at the fourth falling edge
         while (ext_osc_valid_flag_o !== 1'b1 && n < 8) begin
            @(negedge clk_i);
            n++;
         end
         chk(8'(n), 8'h4);
         @(posedge clk_i);
         sel_we_i <= 1;
         sel_wdata_i <= 3'h1;
         @(posedge clk_i);
         sel_we_i <= 0;
         repeat (2) @(negedge clk_i);
         chk(8'(sysclk_source_select_o), 8'h1);
         chk(8'(lp_osc_enable_o), 8'h0);
      end
      finish_test();
   end
endmodule : osc_source_ctrl_tb
`default_nettype wire
